// [rtl/disk_write_pkg.sv]
// Constants, carriers and helper functions for the disk write parcel path.
// Assumes a single core clock and a sync pulse that marks sync phase 0.
package disk_write_pkg;

  // Sync cycle
  localparam logic [2:0] SYNC_LAST  = 3'h5;
  localparam logic [2:0] PHASE_MODE = 3'h2;
  localparam logic [2:0] PHASE_INC  = 3'h3;

  // Word transfer shape
  localparam logic [2:0] IN_SLICE_LAST  = 3'h5;
  localparam logic [2:0] OUT_SLICE_LAST = 3'h4;
  localparam logic [1:0] PARCEL_LAST    = 2'h3;
  localparam logic [1:0] ACC_LAST       = 2'h3;

  // Function commands and modifier fields
  localparam logic [3:0] CMD_READ_ECC   = 4'h1;
  localparam logic [3:0] CMD_LOAD_COUNT = 4'h4;
  localparam logic [3:0] CMD_START      = 4'h5;
  localparam int         MOD_IRQ_EN     = 0;

  // Parcel counts
  localparam int         DATA_PARCELS = 20000;
  localparam int         PARCEL_CNT_W = 15;
  localparam logic [6:0] DEFECT_LAST  = 7'h6d;
  localparam logic [4:0] ECC_LAST     = 5'h13;

  typedef struct packed {
    logic       par;
    logic [7:0] data;
  } bus_byte_type;

  typedef struct packed {
    bus_byte_type b;
    bus_byte_type a;
  } parcel_type;

  typedef enum logic [1:0] {FN_IDLE, FN_CMD, FN_ACC} fn_state_type;
  typedef enum logic [2:0] {XP_IDLE, XP_DEFECT, XP_DATA, XP_ECC, XP_DONE} xfer_phase_type;
  typedef enum logic [2:0] {FETCH_IDLE, FETCH_MODE, FETCH_INC, FETCH_CAPTURE,
                            FETCH_PASS} fetch_state_type;
  typedef enum logic [1:0] {LINK_IDLE, LINK_INIT, LINK_WAIT, LINK_SEND} link_state_type;

  // Odd parity on each byte of a parcel
  function automatic parcel_type make_parcel(input logic [15:0] d);
    parcel_type p;
    p.a.data = d[7:0];
    p.a.par  = ~^d[7:0];
    p.b.data = d[15:8];
    p.b.par  = ~^d[15:8];
    return p;
  endfunction

  // Word: data [63:0], Hamming checks [70:64], overall parity [71].
  // Result: {overall parity, 7-bit syndrome}.
  function automatic logic [7:0] secded_syndrome(input logic [71:0] w);
    logic [6:0] s;
    logic       b;
    int         d;
    int         k;
    s = '0;
    b = 1'b0;
    d = 0;
    k = 0;
    for (int pos = 1; pos < 72; pos++) begin
      if ((pos & (pos - 1)) == 0) begin
        b = w[64 + k];
        k++;
      end else begin
        b = w[d];
        d++;
      end
      if (b) begin
        s = s ^ pos[6:0];
      end
    end
    return {^w, s};
  endfunction

endpackage

// [rtl/parcel_buffer.sv]
// Small FIFO with valid/ready on both sides; flip-flop storage.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`timescale 1ns/1ps
module parcel_buffer #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,  // Core clock
  input  wire logic             rst_n,     // Synchronous reset, active low
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Offered word
  output logic                  out_valid, // Word held
  input  wire logic             out_ready, // Drain takes the word
  output logic      [WIDTH-1:0] out_data   // Oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : bad_depth
    $error("parcel_buffer depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } buf_state_type;

  buf_state_type s;
  buf_state_type next_s;
  logic          push;
  logic          pop;

  assign in_ready  = (s.count != (AW + 1)'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rd];

  always_comb begin
    next_s = s;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [rtl/disk_write_parcel_path.sv]
// Disk channel write path: function decode, buffer-board word fetch,
// SECDED check, parcel split, parcel/defect/ECC counting, drive handshake.
// Assumes inputs synchronous to core_clk and a sync pulse every 6 clocks.
`timescale 1ns/1ps

// Notes on behaviour
// - Function gives modifier, then command, then four accumulator nibbles if needed.
// - Even channel uses pointer a, odd channel uses pointer b.
// - Pointer strobe at sync phase 2 selects buffer board mode.
// - Pointer strobe at sync phase 3 advances that pointer by one.
// - Words from the buffer board arrive as six 12-bit slices.
// - Each word goes to output buffer with strobe, 16 bits over 5 clocks.
// - Output buffer checks SECDED, adds two parity bits per parcel, reports errors.
// - Parcel available flag triggers a parcel advance pulse, then parcel data follows.
// - Every parcel advance decrements the transfer counter.
// - Every data-phase advance counts a parcel and writes it; data ends at 20,000.
// - Then 20 ECC parcels go out with ECC write and gate strobes.
// - With a defect pad, the defect counter counts 110 parcels.
// - During the defect pad no write strobe; the same parcel repeats.
// - Write strobe feeds ECC accumulator; command 1 reads the ECC back.
// - On each write strobe the output buffer presents its next parcel.
// - Each parcel puts 8 data plus 1 parity on A and B, raises master strobe.
// - Master strobe falls only after the slave strobe has fallen.
// - Output buffer requests next word; it is latched at the right sync phase.
// - With ECC write and gate, inverted ECC goes to the drive.
// - Interrupt rises when done sets while the channel interrupt is enabled.
// - Transfer initiate rises only after the slave strobe is low.
module disk_write_parcel_path #(
  parameter int DATA_PARCELS = disk_write_pkg::DATA_PARCELS,
  parameter int FIFO_DEPTH   = 2
) (
  input  wire logic                       core_clk,                  // Core clock
  input  wire logic                       rst_n,                     // Sync reset
  input  wire logic                       sync_pulse,                // Marks phase 0
  input  wire logic                       processor_function_strobe, // Function start
  input  wire logic [3:0]                 function_data,             // Function nibble
  input  wire logic                       channel_odd,               // Odd channel
  input  wire logic                       defect_pad_present,        // Defect pad here
  input  wire logic [11:0]                buffer_slice,              // Board data
  output logic                            pointer_even_strobe,       // Pointer a strobe
  output logic                            pointer_odd_strobe,        // Pointer b strobe
  output logic                            word_to_outbuf_strobe,     // Word passed
  input  wire logic                       slave_strobe,              // Drive request
  output logic                            master_strobe,             // Parcel on bus
  output logic                            transfer_initiate,         // Transfer active
  output disk_write_pkg::parcel_type      drive_bus,                 // A and B buses
  output logic                            secded_single,             // Single-bit error
  output logic                            secded_double,             // Double-bit error
  output logic [15:0]                     ecc_readout,               // ECC read value
  output logic                            ecc_readout_valid,         // ECC read pulse
  output logic                            busy,                      // Transfer running
  output logic                            done,                      // Transfer ended
  output logic                            channel_interrupt          // Interrupt
);
  localparam int CW = disk_write_pkg::PARCEL_CNT_W;

  if (DATA_PARCELS < 1 || DATA_PARCELS >= (1 << CW)) begin : bad_parcels
    $error("DATA_PARCELS out of range for the parcel counter");
  end

  localparam logic [CW-1:0] DATA_LAST = CW'(DATA_PARCELS - 1);

  typedef struct packed {
    logic [2:0]                     phase;
    disk_write_pkg::fn_state_type   fn;
    logic [1:0]                     fn_cnt;
    logic [3:0]                     modifier;
    logic [15:0]                    acc;
    logic                           busy;
    logic                           done;
    logic                           irq_en;
    logic                           irq;
    logic                           odd;
    disk_write_pkg::xfer_phase_type xp;
    logic [15:0]                    xfer_cnt;
    logic [CW-1:0]                  parcel_cnt;
    logic [6:0]                     defect_cnt;
    logic [4:0]                     ecc_cnt;
    logic [15:0]                    ecc_acc;
    disk_write_pkg::fetch_state_type fetch;
    logic [2:0]                     fcnt;
    logic [71:0]                    cap;
    logic [79:0]                    sr;
    logic [63:0]                    word;
    logic                           word_valid;
    logic [1:0]                     pidx;
    logic                           ptr_even;
    logic                           ptr_odd;
    logic                           word_strobe;
    logic                           sec_single;
    logic                           sec_double;
    logic [15:0]                    ecc_out;
    logic                           ecc_out_valid;
    disk_write_pkg::link_state_type link;
    logic                           initiate;
    logic                           master;
    disk_write_pkg::parcel_type     bus;
  } path_state_type;

  path_state_type             s;
  path_state_type             next_s;
  logic                       advance;
  logic                       avail;
  logic                       pop;
  logic [15:0]                cur_data;
  logic [7:0]                 syn;
  disk_write_pkg::parcel_type push_parcel;
  logic                       buf_in_ready;
  logic                       buf_out_valid;
  logic [17:0]                buf_out_data;

  parcel_buffer #(
    .WIDTH (18),
    .DEPTH (FIFO_DEPTH)
  ) i_parcel_buffer (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (advance),
    .in_ready  (buf_in_ready),
    .in_data   (push_parcel),
    .out_valid (buf_out_valid),
    .out_ready (pop),
    .out_data  (buf_out_data)
  );

  always_comb begin
    next_s      = s;
    advance     = 1'b0;
    pop         = 1'b0;
    syn         = '0;
    cur_data    = s.word[s.pidx*16 +: 16];
    push_parcel = disk_write_pkg::make_parcel(cur_data);
    next_s.ptr_even      = 1'b0;
    next_s.ptr_odd       = 1'b0;
    next_s.word_strobe   = 1'b0;
    next_s.sec_single    = 1'b0;
    next_s.sec_double    = 1'b0;
    next_s.ecc_out_valid = 1'b0;

    // The sync cycle itself is phase 0, so phase 1 follows it
    next_s.phase = (sync_pulse ? 3'h0 : s.phase) + 3'h1;
    if (!sync_pulse && s.phase == disk_write_pkg::SYNC_LAST) begin
      next_s.phase = '0;
    end

    // Function word decode
    case (s.fn)
      disk_write_pkg::FN_IDLE: begin
        if (processor_function_strobe) begin
          next_s.modifier = function_data;
          next_s.fn       = disk_write_pkg::FN_CMD;
        end
      end
      disk_write_pkg::FN_CMD: begin
        next_s.fn = disk_write_pkg::FN_IDLE;
        if (function_data == disk_write_pkg::CMD_LOAD_COUNT) begin
          next_s.fn     = disk_write_pkg::FN_ACC;
          next_s.fn_cnt = '0;
        end else if (function_data == disk_write_pkg::CMD_START && !s.busy) begin
          next_s.busy       = 1'b1;
          next_s.done       = 1'b0;
          next_s.irq        = 1'b0;
          next_s.irq_en     = s.modifier[disk_write_pkg::MOD_IRQ_EN];
          next_s.odd        = channel_odd;
          next_s.xp         = defect_pad_present ? disk_write_pkg::XP_DEFECT
                                                 : disk_write_pkg::XP_DATA;
          next_s.parcel_cnt = '0;
          next_s.defect_cnt = '0;
          next_s.ecc_cnt    = '0;
          next_s.ecc_acc    = '0;
          next_s.word_valid = 1'b0;
          next_s.link       = disk_write_pkg::LINK_INIT;
        end else if (function_data == disk_write_pkg::CMD_READ_ECC) begin
          next_s.ecc_out       = s.ecc_acc;
          next_s.ecc_out_valid = 1'b1;
        end
      end
      disk_write_pkg::FN_ACC: begin
        next_s.acc    = {s.acc[11:0], function_data};
        next_s.fn_cnt = s.fn_cnt + 2'h1;
        if (s.fn_cnt == disk_write_pkg::ACC_LAST) begin
          next_s.xfer_cnt = {s.acc[11:0], function_data};
          next_s.fn       = disk_write_pkg::FN_IDLE;
        end
      end
      default: next_s.fn = disk_write_pkg::FN_IDLE;
    endcase

    // Parcel advance: counters, write strobe, ECC strobes
    if (s.xp == disk_write_pkg::XP_DEFECT || s.xp == disk_write_pkg::XP_DATA) begin
      avail = s.word_valid;
    end else begin
      avail = (s.xp == disk_write_pkg::XP_ECC);
    end
    if (avail && buf_in_ready && s.xfer_cnt != '0) begin
      advance         = 1'b1;
      next_s.xfer_cnt = s.xfer_cnt - 16'h1;
      case (s.xp)
        disk_write_pkg::XP_DEFECT: begin
          next_s.defect_cnt = s.defect_cnt + 7'h1;
          if (s.defect_cnt == disk_write_pkg::DEFECT_LAST) begin
            next_s.xp = disk_write_pkg::XP_DATA;
          end
        end
        disk_write_pkg::XP_DATA: begin
          next_s.ecc_acc    = {s.ecc_acc[14:0], s.ecc_acc[15]} ^ cur_data;
          next_s.pidx       = s.pidx + 2'h1;
          next_s.parcel_cnt = s.parcel_cnt + 1'b1;
          if (s.pidx == disk_write_pkg::PARCEL_LAST) begin
            next_s.word_valid = 1'b0;
          end
          if (s.parcel_cnt == DATA_LAST) begin
            next_s.xp = disk_write_pkg::XP_ECC;
          end
        end
        default: begin
          push_parcel     = disk_write_pkg::make_parcel(~s.ecc_acc);
          next_s.ecc_acc  = {s.ecc_acc[14:0], s.ecc_acc[15]};
          next_s.ecc_cnt  = s.ecc_cnt + 5'h1;
          if (s.ecc_cnt == disk_write_pkg::ECC_LAST) begin
            next_s.xp = disk_write_pkg::XP_DONE;
          end
        end
      endcase
    end

    // Word fetch from the buffer board
    case (s.fetch)
      disk_write_pkg::FETCH_IDLE: begin
        if (s.busy && !s.word_valid && s.xfer_cnt != '0 &&
            s.link != disk_write_pkg::LINK_IDLE &&
            (s.xp == disk_write_pkg::XP_DEFECT || s.xp == disk_write_pkg::XP_DATA)) begin
          next_s.fetch = disk_write_pkg::FETCH_MODE;
        end
      end
      disk_write_pkg::FETCH_MODE: begin
        if (next_s.phase == disk_write_pkg::PHASE_MODE) begin
          next_s.ptr_even = !s.odd;
          next_s.ptr_odd  = s.odd;
          next_s.fetch    = disk_write_pkg::FETCH_INC;
        end
      end
      disk_write_pkg::FETCH_INC: begin
        if (next_s.phase == disk_write_pkg::PHASE_INC) begin
          next_s.ptr_even = !s.odd;
          next_s.ptr_odd  = s.odd;
          next_s.fcnt     = '0;
          next_s.fetch    = disk_write_pkg::FETCH_CAPTURE;
        end
      end
      disk_write_pkg::FETCH_CAPTURE: begin
        next_s.cap  = {buffer_slice, s.cap[71:12]};
        next_s.fcnt = s.fcnt + 3'h1;
        if (s.fcnt == disk_write_pkg::IN_SLICE_LAST) begin
          next_s.fcnt        = '0;
          next_s.word_strobe = 1'b1;
          next_s.fetch       = disk_write_pkg::FETCH_PASS;
        end
      end
      default: begin
        next_s.sr   = {s.cap[15:0], s.sr[79:16]};
        next_s.cap  = {16'h0, s.cap[71:16]};
        next_s.fcnt = s.fcnt + 3'h1;
        if (s.fcnt == disk_write_pkg::OUT_SLICE_LAST) begin
          syn               = disk_write_pkg::secded_syndrome(next_s.sr[71:0]);
          next_s.sec_single = syn[7];
          next_s.sec_double = !syn[7] && (syn[6:0] != '0);
          next_s.word       = next_s.sr[63:0];
          next_s.word_valid = 1'b1;
          next_s.pidx       = '0;
          next_s.fetch      = disk_write_pkg::FETCH_IDLE;
        end
      end
    endcase

    // Drive handshake
    case (s.link)
      disk_write_pkg::LINK_IDLE: begin
        next_s.initiate = 1'b0;
        next_s.master   = 1'b0;
      end
      disk_write_pkg::LINK_INIT: begin
        if (!slave_strobe) begin
          next_s.initiate = 1'b1;
          next_s.link     = disk_write_pkg::LINK_WAIT;
        end
      end
      disk_write_pkg::LINK_WAIT: begin
        if (slave_strobe && buf_out_valid) begin
          pop           = 1'b1;
          next_s.bus    = buf_out_data;
          next_s.master = 1'b1;
          next_s.link   = disk_write_pkg::LINK_SEND;
        end else if (!slave_strobe && !buf_out_valid &&
                     (s.xp == disk_write_pkg::XP_DONE || s.xfer_cnt == '0)) begin
          next_s.initiate = 1'b0;
          next_s.busy     = 1'b0;
          next_s.done     = 1'b1;
          next_s.irq      = s.irq_en;
          next_s.xp       = disk_write_pkg::XP_IDLE;
          next_s.link     = disk_write_pkg::LINK_IDLE;
        end
      end
      default: begin
        if (!slave_strobe) begin
          next_s.master = 1'b0;
          next_s.link   = disk_write_pkg::LINK_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pointer_even_strobe   = s.ptr_even;
  assign pointer_odd_strobe    = s.ptr_odd;
  assign word_to_outbuf_strobe = s.word_strobe;
  assign master_strobe         = s.master;
  assign transfer_initiate     = s.initiate;
  assign drive_bus             = s.bus;
  assign secded_single         = s.sec_single;
  assign secded_double         = s.sec_double;
  assign ecc_readout           = s.ecc_out;
  assign ecc_readout_valid     = s.ecc_out_valid;
  assign busy                  = s.busy;
  assign done                  = s.done;
  assign channel_interrupt     = s.irq;
endmodule

// [sim/disk_write_parcel_path_props.sv]
// Port assertions for the disk write parcel path.
// Assumes sync_pulse marks phase 0 once every six clocks.
`timescale 1ns/1ps
module disk_write_parcel_path_props (
  input wire logic                       core_clk,              // Clock
  input wire logic                       rst_n,                 // Reset
  input wire logic                       sync_pulse,            // Phase 0
  input wire logic                       channel_odd,           // Odd channel
  input wire logic                       pointer_even_strobe,   // Pointer a
  input wire logic                       pointer_odd_strobe,    // Pointer b
  input wire logic                       word_to_outbuf_strobe, // Word passed
  input wire logic                       slave_strobe,          // Drive request
  input wire logic                       master_strobe,         // Parcel strobe
  input wire logic                       transfer_initiate,     // Transfer active
  input wire disk_write_pkg::parcel_type drive_bus,             // A and B buses
  input wire logic                       done                   // Ended
);
  logic [2:0] ph;
  wire  [2:0] cur = sync_pulse ? 3'h0 : ph;
  wire        ptr = pointer_even_strobe | pointer_odd_strobe;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk) begin
    ph <= (cur == 3'h5) ? 3'h0 : cur + 3'h1;
  end
  a_ptr_phase: assert property (ptr |-> cur == 3'h2 || cur == 3'h3)
    else $error("pointer strobe off phases 2 and 3");
  a_mode_then_inc: assert property (ptr && cur == 3'h2 |=> ptr && $stable(pointer_odd_strobe))
    else $error("mode strobe not followed by increment strobe");
  a_ptr_channel: assert property (ptr |-> pointer_odd_strobe == channel_odd && !(pointer_even_strobe && pointer_odd_strobe))
    else $error("pointer strobe does not match channel");
  a_word_after_fetch: assert property (word_to_outbuf_strobe |-> $past(ptr, 6))
    else $error("word strobe not six cycles after capture start");
  a_master_cause: assert property ($rose(master_strobe) |-> $past(slave_strobe) && transfer_initiate)
    else $error("master strobe without request");
  a_master_holds: assert property (master_strobe && slave_strobe |=> master_strobe)
    else $error("master strobe dropped while slave high");
  a_master_release: assert property (master_strobe && !slave_strobe |=> !master_strobe)
    else $error("master strobe kept after slave dropped");
  a_bus_parity: assert property (master_strobe |-> ^drive_bus.a && ^drive_bus.b)
    else $error("parcel parity not odd");
  a_init_after: assert property ($rose(transfer_initiate) |-> !$past(slave_strobe))
    else $error("initiate rose while slave strobe high");
  c_parcel: cover property ($rose(master_strobe));
  c_word: cover property (word_to_outbuf_strobe);
  c_done: cover property ($rose(done));
endmodule
bind disk_write_parcel_path disk_write_parcel_path_props i_disk_write_parcel_path_props (
  .core_clk, .rst_n, .sync_pulse, .channel_odd, .pointer_even_strobe, .pointer_odd_strobe,
  .word_to_outbuf_strobe, .slave_strobe, .master_strobe, .transfer_initiate, .drive_bus, .done);

// [sim/drive_slave_model.sv]
// Drive side of the parcel handshake: requests, takes and reports parcels.
// Assumes master_strobe rises only in answer to slave_strobe.
`timescale 1ns/1ps
module drive_slave_model (
  input  wire logic                       core_clk,          // Clock
  input  wire logic                       rst_n,             // Reset
  input  wire logic                       slow,              // Pause between requests
  input  wire logic [15:0]                limit,             // Parcels to take
  input  wire logic                       transfer_initiate, // Transfer active
  input  wire logic                       master_strobe,     // Parcel strobe
  input  wire disk_write_pkg::parcel_type drive_bus,         // A and B buses
  output logic                            slave_strobe,      // Parcel request
  output logic                            got,               // Parcel taken
  output logic [15:0]                     got_data           // Taken parcel
);
  int         taken;
  logic [2:0] gap;
  always_ff @(posedge core_clk) begin
    got <= 1'b0;
    if (!rst_n || !transfer_initiate) begin
      slave_strobe <= 1'b0;
      taken <= 0;
      gap <= 3'h0;
    end else if (slave_strobe && master_strobe) begin
      slave_strobe <= 1'b0;
      got <= 1'b1;
      got_data <= {drive_bus.b.data, drive_bus.a.data};
      taken <= taken + 1;
      gap <= slow ? 3'h5 : 3'h0;
    end else if (gap != 3'h0) begin
      gap <= gap - 3'h1;
    end else if (!slave_strobe && !master_strobe && taken < limit) begin
      slave_strobe <= 1'b1;
    end
  end
endmodule

// [sim/tb_disk_write_parcel_path.sv]
// Testbench: buffer board, function port and drive model around the write path.
// Assumes the drive model and the bound checker.
`timescale 1ns/1ps
module tb_disk_write_parcel_path;
  localparam int DP = 8;
  logic                       core_clk = 1'b0, rst_n = 1'b0, sync_pulse = 1'b1, pend = 1'b0;
  logic                       processor_function_strobe = 1'b0, channel_odd = 1'b0;
  logic                       defect_pad_present = 1'b0, slow = 1'b0;
  logic [3:0]                 function_data = 4'h0;
  logic [11:0]                buffer_slice = 12'h000;
  logic [15:0]                limit = 16'h0000, got_data, ecc_readout;
  logic                       slave_strobe, got, pe, po, ms, ti, ss, sd, erv, busy, done, irq;
  disk_write_pkg::parcel_type drive_bus;
  logic [71:0]                mem [8];
  logic [15:0]                rx [$];
  int                         failures = 0, compares = 0, widx = 0, ph = 0, n_s, n_d, n_r;
  disk_write_parcel_path #(.DATA_PARCELS(DP)) i_disk_write_parcel_path (.core_clk, .rst_n,
    .sync_pulse, .processor_function_strobe, .function_data, .channel_odd, .defect_pad_present,
    .buffer_slice, .pointer_even_strobe(pe), .pointer_odd_strobe(po), .word_to_outbuf_strobe(),
    .slave_strobe, .master_strobe(ms), .transfer_initiate(ti), .drive_bus, .secded_single(ss),
    .secded_double(sd), .ecc_readout, .ecc_readout_valid(erv), .busy, .done,
    .channel_interrupt(irq));
  drive_slave_model i_drive_slave_model (.core_clk, .rst_n, .slow, .limit,
    .transfer_initiate(ti), .master_strobe(ms), .drive_bus, .slave_strobe, .got, .got_data);
  always #4 core_clk = ~core_clk;
  // Buffer board: reads the addressed word by phase, advances after the sixth slice.
  // Outputs are sampled mid-cycle, clear of the edge that launches them.
  always @(negedge core_clk) begin
    if ((pe || po) && ph == 3) pend <= 1'b1;
    if (pend && ph == 2) begin
      widx <= widx + 1;
      pend <= 1'b0;
    end
    if (got) rx.push_back(got_data);
    n_s += ss;
    n_d += sd;
    n_r += erv;
  end
  always @(posedge core_clk) begin
    #1;
    ph = (ph == 5) ? 0 : ph + 1;
    sync_pulse = (ph == 0);
    buffer_slice = mem[widx % 8][12 * ((ph + 3) % 6) +: 12];
  end
  function automatic logic [71:0] enc(input logic [63:0] d);
    logic [6:0] s;
    int         j;
    s = 7'h00;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[j]) s = s ^ p[6:0];
        j++;
      end
    end
    return {^d ^ ^s, s, d};
  endfunction
  function automatic logic [15:0] pexp(input int i);
    return mem[i / 4][16 * (i % 4) +: 16];
  endfunction
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic fn(input logic [3:0] md, input logic [3:0] cmd, input logic [15:0] cnt);
    processor_function_strobe = 1'b1;
    function_data = md;
    tick(1);
    processor_function_strobe = 1'b0;
    function_data = cmd;
    tick(1);
    for (int i = 3; i >= 0 && cmd == 4'h4; i--) begin
      function_data = cnt[4 * i +: 4];
      tick(1);
    end
    function_data = 4'h0;
    tick(2);
  endtask
  task automatic run(input logic ie, input logic odd, input logic dfct, input int n,
                     input logic poke);
    rx.delete();
    widx = 0;
    n_s = 0;
    n_d = 0;
    channel_odd = odd;
    defect_pad_present = dfct;
    limit = n[15:0];
    fn(4'h0, 4'h4, n[15:0]);
    fn({3'h0, ie}, 4'h5, 16'h0000);
    chk("busy", 1, busy);
    if (poke) fn(4'h0, 4'h5, 16'h0000);
    for (int i = 0; i < 20000 && done !== 1'b1; i++) tick(1);
    chk("done", 1, done);
    if (done !== 1'b1) tally_and_finish();
    chk("parcels", n[15:0], rx.size());
    chk("interrupt", ie, irq);
  endtask
  task automatic t_plain;
    logic [15:0] acc;
    acc = 16'h0000;
    mem[0][71] = ~mem[0][71];
    run(1'b1, 1'b0, 1'b0, DP + 20, 1'b0);
    for (int i = 0; i < DP; i++) begin
      chk("data parcel", pexp(i), rx[i]);
      acc = {acc[14:0], acc[15]} ^ pexp(i);
    end
    for (int i = 0; i < 20; i++) begin
      chk("ecc parcel", ~acc, rx[DP + i]);
      acc = {acc[14:0], acc[15]};
    end
    chk("single errors", 1, n_s);
    chk("double errors", 0, n_d);
    mem[0][71] = ~mem[0][71];
    n_r = 0;
    fn(4'h0, 4'h1, 16'h0000);
    chk("ecc reads", 1, n_r);
    chk("ecc readout", acc, ecc_readout);
  endtask
  task automatic t_defect;
    mem[1][65:64] = ~mem[1][65:64];
    slow = 1'b1;
    run(1'b0, 1'b1, 1'b1, 110 + DP + 20, 1'b0);
    for (int i = 0; i < 110; i++) chk("pad parcel", pexp(0), rx[i]);
    chk("double errors", 1, n_d);
    mem[1][65:64] = ~mem[1][65:64];
    slow = 1'b0;
  endtask
  task automatic t_short;
    run(1'b1, 1'b0, 1'b0, DP, 1'b1);
    for (int i = 0; i < DP; i++) chk("short parcel", pexp(i), rx[i]);
  endtask
  initial begin
    for (int w = 0; w < 8; w++) begin
      mem[w] = enc({w[7:0], 8'h3c, w[7:0] ^ 8'ha5, 8'h96, ~w[15:0], 16'h5a01 + w[15:0]});
    end
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_plain();
    t_defect();
    t_short();
    tally_and_finish();
  end
endmodule
